// ==== port_timing_regs.vh ====
`ifndef PORT_TIMING_REGS_VH
`define PORT_TIMING_REGS_VH

// Register indices; byte address is four times the index
`define BANK_CTRL_IDX 8'h00
`define MODE_ONE_IDX 8'h2c
`define MODE_TWO_IDX 8'h2e
`define BIT_COUNT_IDX 8'h30
`define SLOT_OFFSET_IDX 8'h32
`define BIT_SHIFT_IDX 8'h34
`define SUBCHANNEL_IDX 8'h36
`define STATUS_IDX 8'h3e

// Reset values
`define BANK_CTRL_RST 8'h00
`define MODE_ONE_RST 8'h00
`define MODE_TWO_RST 8'h00
`define BIT_COUNT_RST 8'hff
`define SLOT_OFFSET_RST 8'h00
`define BIT_SHIFT_RST 8'h00
`define SUBCHANNEL_RST 8'h00

// Field positions in port_mode_reg_one
`define CLK_SRC_BIT 7
`define SYNC_EDGE_BIT 6
`define PRESCALE_HI 5
`define PRESCALE_LO 4
`define PMODE_HI 3
`define PMODE_LO 2
`define ALT_IN1_BIT 1
`define ALT_IN0_BIT 0

// Field positions in port_mode_reg_two
`define FSHAPE_HI 7
`define FSHAPE_LO 5
`define CLK_RATE_BIT 4
`define TX_EDGE_BIT 3
`define RX_EDGE_BIT 2
`define CNT_HI_HI 1
`define CNT_HI_LO 0

// Field positions in port_bit_shift
`define DS_SHIFT_HI 6
`define DS_SHIFT_LO 4
`define US_SHIFT_HI 3
`define US_SHIFT_LO 0

// Bank select bit in bank control
`define BANK_SEL_BIT 0

// Prescaler codes
`define PRESCALE_DIV2 2'h0
`define PRESCALE_DIV15 2'h1
`define PRESCALE_DIV1 2'h2

// Frame output shapes
`define FSHAPE_PBC 3'h2
`define FSHAPE_MBUS 3'h3
`define FSHAPE_MBUS_PP 3'h6

// Port modes
`define PMODE_0 2'h0
`define PMODE_1 2'h1
`define PMODE_2 2'h2
`define PMODE_3 2'h3

// Slot offset bias and bit shift bias
`define SLOT_BIAS 13'h0012
`define SHIFT_ADJ_TOP 4'ha

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== pin_sync.v ====
`timescale 1ns/1ps
// Three flops; output moves only when stages two and three agree
module pin_sync #(
  parameter WIDTH = 1
) (
  input wire clk, // System clock
  input wire reset, // Synchronous reset
  input wire ce, // Clock enable
  input wire [WIDTH-1:0] pin_in, // Asynchronous pins
  output reg [WIDTH-1:0] stable_q // Filtered level
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer i;

  always @(posedge clk) begin
    if (reset) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      stable_q <= {WIDTH{1'b0}};
    end else if (ce) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          stable_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // pin_sync

// ==== clk_prescaler.v ====
`timescale 1ns/1ps
`include "port_timing_regs.vh"
// Turns source clock edges into port clock half-period ticks
module clk_prescaler (
  input wire clk, // System clock
  input wire reset, // Synchronous reset
  input wire ce, // Clock enable
  input wire src_edge, // Any edge of the selected source clock
  input wire [1:0] code, // Prescaler code
  output reg tick_q // One-cycle half-period tick
);
  reg [1:0] acc_q;
  reg [1:0] acc_d;
  reg tick_d;

  // 1/1.5 adds two per edge and fires per three, so two ticks per three edges
  always @* begin
    acc_d = acc_q;
    tick_d = 1'b0;
    if (src_edge) begin
      case (code)
        `PRESCALE_DIV2: begin
          tick_d = acc_q[0];
          acc_d = {1'b0, ~acc_q[0]};
        end
        `PRESCALE_DIV15: begin
          if (acc_q >= 2'd1) begin
            tick_d = 1'b1;
            acc_d = acc_q - 2'd1;
          end else begin
            acc_d = acc_q + 2'd2;
          end
        end
        default: begin
          tick_d = 1'b1;
          acc_d = 2'd0;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      acc_q <= 2'd0;
      tick_q <= 1'b0;
    end else if (ce) begin
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end
endmodule // clk_prescaler

// ==== port_timing_setup.v ====
`timescale 1ns/1ps
`include "port_timing_regs.vh"
// How it works
// - Clock source bit 0 uses PCM clock and sync; 1 uses port pins as inputs.
// - Port sync edge bit: 1 takes frame sync on rising, 0 on falling edge.
// - Prescaler code 00 divides by 2, 01 by 1.5, 10 passes undivided.
// - Two-bit port mode field picks one of modes 0 to 3.
// - Alternative inputs: zero in modes 0/3, in1 also zero in mode 2; in0 line 0/2, in1 line 1/3.
// - PCM-clocked: frame output shape 010, 011 or 110 forms frame sync output.
// - PCM-clocked: clock rate bit 0 gives data-rate clock, 1 double rate.
// - Transmit edge bit: 0 drives on rising, 1 on falling clock edge.
// - Receive edge bit: 0 samples on falling, 1 on rising clock edge.
// - Frame bits minus one is ten bits: low eight plus two in mode two.
// - Shift code 000 two bits right, 001 one right, codes 2 to 7 shift left; higher upstream codes do not.
// - Shift counts from PCM frame sync or port frame sync per clock source.
// - Four subchannel fields, one per port; mode 3 also covers port four above.
// - Codes 00/10 select bits 7..4, codes 01/11 bits 3..0.
module port_timing_setup (
  input wire clk, // 40 MHz system clock
  input wire reset, // Synchronous reset, active high
  input wire ce, // Clock enable, freezes all state when low
  input wire [31:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [31:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire pcm_side_clock, // PCM-side data clock pin
  input wire pcm_side_frame_sync, // PCM-side frame sync pin
  input wire port_data_clock_in, // Port data clock pin, input side
  output reg port_data_clock_out, // Port data clock pin, output side
  output reg port_data_clock_oe, // Port data clock pin drive enable
  input wire port_frame_sync_in, // Port frame sync pin, input side
  output reg port_frame_sync_out, // Port frame sync pin, output side
  output reg port_frame_sync_oe, // Port frame sync pin drive enable
  input wire [3:0] upstream_line, // Upstream data lines 0..3
  output reg in0_q, // Routed alternative input 0
  output reg in1_q, // Routed alternative input 1
  output reg tx_strobe_q, // Pulse: drive next outgoing bit
  output reg rx_strobe_q, // Pulse: incoming bit sampled
  output reg frame_start_q, // Pulse: frame sync detected
  output reg [9:0] ds_position_q, // Downstream bit position in frame
  output reg [9:0] us_position_q, // Upstream bit position in frame
  output reg [1:0] port_mode_q, // Active port mode
  output reg [7:0] high_nibble_q // Per port: 1 selects bits 7..4
);
  reg [7:0] bank_q;
  reg [7:0] mode_one_q;
  reg [7:0] mode_two_q;
  reg [7:0] count_q;
  reg [7:0] slot_q;
  reg [7:0] shift_q;
  reg [7:0] subch_q;
  reg [7:0] aw_idx_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [31:0] rdata_d;
  reg rhit_d;
  reg whit_d;
  reg pclk_q;
  reg phase_q;
  reg src_clk_prev_q;
  reg fs_samp_q;
  reg [9:0] bit_cnt_q;
  wire [7:0] pins;
  wire [7:0] ar_idx;
  wire bank_on;
  wire clock_source_select;
  wire port_sync_edge;
  wire [1:0] clock_prescaler;
  wire [1:0] port_mode_field;
  wire [1:0] alt_input_select;
  wire [2:0] frame_output_shape;
  wire clock_output_rate;
  wire transmit_edge_select;
  wire receive_edge_select;
  wire [9:0] frame_bit_count;
  wire [2:0] downstream_bit_shift;
  wire [3:0] upstream_bit_shift;
  wire src_clk;
  wire src_fs;
  wire src_edge;
  wire tick;
  wire pclk_rise;
  wire pclk_fall;
  wire bit_ok;
  wire fs_edge;
  wire frame_start;
  wire bit_adv;
  wire [3:0] ds_adj;
  wire [3:0] us_adj;
  wire [12:0] ds_raw;
  wire [12:0] us_raw;
  wire [12:0] frame_len;
  wire wr_go;

  assign bank_on = bank_q[`BANK_SEL_BIT];
  assign clock_source_select = mode_one_q[`CLK_SRC_BIT];
  assign port_sync_edge = mode_one_q[`SYNC_EDGE_BIT];
  assign clock_prescaler = mode_one_q[`PRESCALE_HI:`PRESCALE_LO];
  assign port_mode_field = mode_one_q[`PMODE_HI:`PMODE_LO];
  assign alt_input_select = mode_one_q[`ALT_IN1_BIT:`ALT_IN0_BIT];
  assign frame_output_shape = mode_two_q[`FSHAPE_HI:`FSHAPE_LO];
  assign clock_output_rate = mode_two_q[`CLK_RATE_BIT];
  assign transmit_edge_select = mode_two_q[`TX_EDGE_BIT];
  assign receive_edge_select = mode_two_q[`RX_EDGE_BIT];
  assign frame_bit_count = {mode_two_q[`CNT_HI_HI:`CNT_HI_LO], count_q};
  assign downstream_bit_shift = shift_q[`DS_SHIFT_HI:`DS_SHIFT_LO];
  assign upstream_bit_shift = shift_q[`US_SHIFT_HI:`US_SHIFT_LO];

  assign ar_idx = s_axi_araddr[9:2];
  assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  always @* begin
    rdata_d = 32'h0000_0000;
    rhit_d = 1'b1;
    if (ar_idx == `BANK_CTRL_IDX) begin
      rdata_d = {24'h000000, bank_q};
    end else if (!bank_on || s_axi_araddr[31:10] != 22'h000000 || s_axi_araddr[1:0] != 2'h0) begin
      rhit_d = 1'b0;
    end else begin
      case (ar_idx)
        `MODE_ONE_IDX: rdata_d = {24'h000000, mode_one_q};
        `MODE_TWO_IDX: rdata_d = {24'h000000, mode_two_q};
        `BIT_COUNT_IDX: rdata_d = {24'h000000, count_q};
        `SLOT_OFFSET_IDX: rdata_d = {24'h000000, slot_q};
        `BIT_SHIFT_IDX: rdata_d = {24'h000000, shift_q};
        `SUBCHANNEL_IDX: rdata_d = {24'h000000, subch_q};
        `STATUS_IDX: rdata_d = {20'h00000, pclk_q, fs_samp_q, bit_cnt_q};
        default: rhit_d = 1'b0;
      endcase
    end
  end

  always @* begin
    case (aw_idx_q)
      `BANK_CTRL_IDX: whit_d = 1'b1;
      `MODE_ONE_IDX, `MODE_TWO_IDX, `BIT_COUNT_IDX, `SLOT_OFFSET_IDX, `BIT_SHIFT_IDX,
      `SUBCHANNEL_IDX: whit_d = bank_on;
      default: whit_d = 1'b0;
    endcase
  end
  always @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_idx_q <= 8'hff;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bank_q <= `BANK_CTRL_RST;
      mode_one_q <= `MODE_ONE_RST;
      mode_two_q <= `MODE_TWO_RST;
      count_q <= `BIT_COUNT_RST;
      slot_q <= `SLOT_OFFSET_RST;
      shift_q <= `BIT_SHIFT_RST;
      subch_q <= `SUBCHANNEL_RST;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        // Out-of-window or misaligned addresses land on an unmapped index
        aw_idx_q <= (s_axi_awaddr[31:10] == 22'h000000 && s_axi_awaddr[1:0] == 2'h0) ? s_axi_awaddr[9:2] : 8'hff;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= whit_d ? `RESP_OKAY : `RESP_SLVERR;
        if (whit_d && wstrb_q[0]) begin
          case (aw_idx_q)
            `BANK_CTRL_IDX: bank_q <= wdata_q[7:0];
            `MODE_ONE_IDX: mode_one_q <= wdata_q[7:0];
            `MODE_TWO_IDX: mode_two_q <= wdata_q[7:0];
            `BIT_COUNT_IDX: count_q <= wdata_q[7:0];
            `SLOT_OFFSET_IDX: slot_q <= wdata_q[7:0];
            `BIT_SHIFT_IDX: shift_q <= {1'b0, wdata_q[6:0]};
            `SUBCHANNEL_IDX: subch_q <= wdata_q[7:0];
            default: bank_q <= bank_q;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rhit_d ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
  pin_sync #(.WIDTH(8)) u_pin_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .pin_in({upstream_line, pcm_side_clock, pcm_side_frame_sync, port_data_clock_in, port_frame_sync_in}),
    .stable_q(pins)
  );

  assign src_clk = clock_source_select ? pins[1] : pins[3];
  assign src_fs = clock_source_select ? pins[0] : pins[2];
  assign src_edge = src_clk ^ src_clk_prev_q;
  clk_prescaler u_clk_prescaler (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .src_edge(src_edge),
    .code(clock_prescaler),
    .tick_q(tick)
  );
  assign pclk_rise = tick & ~pclk_q;
  assign pclk_fall = tick & pclk_q;
  // double-rate clock spends two periods per bit
  assign bit_ok = ~clock_output_rate | phase_q;
  assign fs_edge = port_sync_edge ? pclk_rise : pclk_fall;
  assign frame_start = fs_edge & src_fs & ~fs_samp_q;
  assign bit_adv = pclk_rise & bit_ok;
  // code to bias: 0,1 shift right, others 8-code left; upstream codes above 10 act as code 0
  assign ds_adj = (downstream_bit_shift < 3'd2) ? {1'b0, downstream_bit_shift} :
    (`SHIFT_ADJ_TOP - {1'b0, downstream_bit_shift});
  assign us_adj = (upstream_bit_shift < 4'd2) ? upstream_bit_shift :
    ((upstream_bit_shift <= `SHIFT_ADJ_TOP) ? (`SHIFT_ADJ_TOP - upstream_bit_shift) : 4'h0);
  assign frame_len = {3'b000, frame_bit_count} + 13'd1;
  // slot offset carries a bias of two slots
  assign ds_raw = {3'b000, bit_cnt_q} + `SLOT_BIAS - {2'b00, slot_q, 3'b000} - {9'h000, ds_adj};
  assign us_raw = {3'b000, bit_cnt_q} + `SLOT_BIAS - {2'b00, slot_q, 3'b000} - {9'h000, us_adj};

  always @(posedge clk) begin
    if (reset) begin
      src_clk_prev_q <= 1'b0;
      pclk_q <= 1'b0;
      phase_q <= 1'b0;
      fs_samp_q <= 1'b0;
      bit_cnt_q <= 10'h000;
      frame_start_q <= 1'b0;
      tx_strobe_q <= 1'b0;
      rx_strobe_q <= 1'b0;
      in0_q <= 1'b0;
      in1_q <= 1'b0;
      ds_position_q <= 10'h000;
      us_position_q <= 10'h000;
      port_data_clock_out <= 1'b0;
      port_data_clock_oe <= 1'b0;
      port_frame_sync_out <= 1'b0;
      port_frame_sync_oe <= 1'b0;
      port_mode_q <= `PMODE_0;
      high_nibble_q <= 8'h00;
    end else if (ce) begin
      src_clk_prev_q <= src_clk;
      if (tick) begin
        pclk_q <= ~pclk_q;
      end
      if (pclk_rise) begin
        phase_q <= clock_output_rate & ~phase_q;
      end
      if (fs_edge) begin
        fs_samp_q <= src_fs;
      end
      frame_start_q <= frame_start;
      // wraps after count plus one bits
      if (frame_start) begin
        bit_cnt_q <= 10'h000;
        phase_q <= 1'b0;
      end else if (bit_adv) begin
        bit_cnt_q <= (bit_cnt_q == frame_bit_count) ? 10'h000 : bit_cnt_q + 10'd1;
      end
      tx_strobe_q <= (transmit_edge_select ? pclk_fall : pclk_rise) & bit_ok;
      rx_strobe_q <= (receive_edge_select ? pclk_rise : pclk_fall) & bit_ok;
      if ((receive_edge_select ? pclk_rise : pclk_fall) & bit_ok) begin
        in0_q <= ((port_mode_field == `PMODE_1 || port_mode_field == `PMODE_2) && alt_input_select[0]) ?
          pins[6] : pins[4];
        in1_q <= (port_mode_field == `PMODE_1 && alt_input_select[1]) ? pins[7] : pins[5];
      end
      // Offsets beyond one frame length are only folded once
      ds_position_q <= ds_raw[12] ? ds_raw[9:0] + frame_len[9:0] : ds_raw[9:0];
      us_position_q <= us_raw[12] ? us_raw[9:0] + frame_len[9:0] : us_raw[9:0];
      port_mode_q <= port_mode_field;
      port_data_clock_out <= pclk_q;
      port_data_clock_oe <= ~clock_source_select;
      port_frame_sync_oe <= ~clock_source_select;
      case (frame_output_shape)
        `FSHAPE_PBC: port_frame_sync_out <= (bit_cnt_q == frame_bit_count);
        `FSHAPE_MBUS: port_frame_sync_out <= (bit_cnt_q == 10'h000);
        `FSHAPE_MBUS_PP: port_frame_sync_out <= (bit_cnt_q <= 10'h001);
        default: port_frame_sync_out <= (bit_cnt_q == 10'h000);
      endcase
      high_nibble_q[3:0] <= {~subch_q[6], ~subch_q[4], ~subch_q[2], ~subch_q[0]};
      high_nibble_q[7:4] <= (port_mode_field == `PMODE_3) ?
        {~subch_q[6], ~subch_q[4], ~subch_q[2], ~subch_q[0]} : 4'h0;
    end
  end
endmodule // port_timing_setup

// ==== port_timing_setup_monitor.sv ====
`timescale 1ns/1ps
module port_timing_setup_monitor (
  input wire clk, // Clock
  input wire reset, // Sync reset
  input wire s_axi_awvalid, // Aw valid
  input wire s_axi_awready, // Aw ready
  input wire s_axi_wvalid, // W valid
  input wire s_axi_wready, // W ready
  input wire s_axi_bvalid, // B valid
  input wire s_axi_bready, // B ready
  input wire s_axi_arvalid, // Ar valid
  input wire s_axi_arready, // Ar ready
  input wire [31:0] s_axi_rdata, // Read data
  input wire s_axi_rvalid, // R valid
  input wire s_axi_rready, // R ready
  input wire port_data_clock_oe, // Clock pin enable
  input wire port_frame_sync_oe, // Sync pin enable
  input wire tx_strobe_q, // Send pulse
  input wire frame_start_q, // Frame pulse
  input wire [1:0] port_mode_q, // Mode
  input wire [7:0] high_nibble_q // Nibble select
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  a_write_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
    else $error("write not answered in two cycles");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  a_write_free: assert property (s_wr_done |=> s_axi_awready && s_axi_wready && !s_axi_bvalid)
    else $error("write channel not freed");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered in one cycle");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before handshake");
  a_reset_idle: assert property ($fell(reset) |-> s_axi_awready && s_axi_arready && !s_axi_rvalid
    && port_mode_q == 2'h0 && high_nibble_q == 8'h00)
    else $error("outputs not at reset values");
  a_oe_pair: assert property (port_data_clock_oe == port_frame_sync_oe)
    else $error("clock and sync pin enables differ");
  a_upper_ports: assert property ((port_mode_q != 2'h3) [*2] |-> high_nibble_q[7:4] == 4'h0)
    else $error("upper ports set outside mode 3");
  a_mode3_mirror: assert property ((port_mode_q == 2'h3) [*2] |-> high_nibble_q[7:4] == high_nibble_q[3:0])
    else $error("upper ports not mirrored in mode 3");
  a_send_pulse: assert property (tx_strobe_q |=> !tx_strobe_q)
    else $error("send strobe longer than one cycle");
  a_frame_pulse: assert property (frame_start_q |=> (!frame_start_q) [*4])
    else $error("frame pulse repeated too soon");
endmodule // port_timing_setup_monitor

bind port_timing_setup port_timing_setup_monitor u_mon (.clk, .reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .port_data_clock_oe, .port_frame_sync_oe, .tx_strobe_q, .frame_start_q,
  .port_mode_q, .high_nibble_q);

// ==== port_side_model.sv ====
`timescale 1ns/1ps
module port_side_model #(
  parameter int HALF = 4, // Cycles per half bit
  parameter int BITS = 16 // Bits per frame
) (
  input wire clk, // Bench clock
  output logic dclk = 1'b0, // Data clock
  output logic fsync = 1'b0 // Frame sync
);
  int cnt = 0;
  int bitn = 0;
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      dclk <= ~dclk;
      if (dclk) begin
        bitn <= (bitn + 1) % BITS;
        // Two bits wide so a halved port clock still catches it
        fsync <= ((bitn + 1) % BITS) < 2;
      end
    end
  end
endmodule // port_side_model

// ==== port_timing_setup_test.sv ====
`timescale 1ns/1ps
`include "port_timing_regs.vh"
module port_timing_setup_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, rv;
  logic [31:0] seed = 32'h10;
  logic [3:0] s_axi_wstrb = 4'hf, upstream_line = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, port_mode_q;
  wire [31:0] s_axi_rdata;
  wire [9:0] ds_position_q, us_position_q;
  wire [7:0] high_nibble_q;
  wire dclk, fsync, clk_out, clk_oe, fs_out, fs_oe, in0_q, in1_q, tx_strobe_q, rx_strobe_q, frame_start_q;
  int num_errors = 0, cmp_count = 0, cyc = 0, ntx, nrx, nfr, ex;
  int mdl [256];
  logic [7:0] idxs [7] = '{8'h00, 8'h2c, 8'h2e, 8'h30, 8'h32, 8'h34, 8'h36};
  logic [7:0] rsts [7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};

  port_side_model far (.clk, .dclk, .fsync);
  port_timing_setup uut (
    .clk, .reset, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pcm_side_clock(dclk),
    .pcm_side_frame_sync(fsync), .port_data_clock_in(clk_oe ? clk_out : dclk), .port_data_clock_out(clk_out),
    .port_data_clock_oe(clk_oe), .port_frame_sync_in(fs_oe ? fs_out : fsync), .port_frame_sync_out(fs_out),
    .port_frame_sync_oe(fs_oe), .upstream_line, .in0_q, .in1_q, .tx_strobe_q, .rx_strobe_q, .frame_start_q,
    .ds_position_q, .us_position_q, .port_mode_q, .high_nibble_q
  );

  always #12.5 clk = ~clk;

  task test_done;
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Bank bit gates everything but bank control itself
  function automatic logic [1:0] exp_resp(input logic [7:0] idx);
    logic ok;
    ok = idx inside {8'h00, 8'h2c, 8'h2e, 8'h30, 8'h32, 8'h34, 8'h36, 8'h3e};
    return (ok && (idx == 8'h00 || mdl[0][0])) ? `RESP_OKAY : `RESP_SLVERR;
  endfunction

  function automatic logic [7:0] exp_hn(input int m, input logic [7:0] sc);
    logic [7:0] e;
    for (int p = 0; p < 4; p++) begin
      e[p] = ~sc[2*p];
      e[p+4] = (m == 3) ? ~sc[2*p] : 1'b0;
    end
    return e;
  endfunction

  function automatic int adj(input int c);
    return c < 2 ? c : (c <= 10 ? 10 - c : 0);
  endfunction

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, exp_resp(idx), "bresp");
    if (exp_resp(idx) == `RESP_OKAY && s_axi_wstrb[0]) mdl[idx] = (idx == 8'h34) ? d & 8'h7f : d;
  endtask

  // Ready goes up with the address and stays until valid is seen
  task automatic rd(input logic [7:0] idx);
    @(posedge clk);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rresp, exp_resp(idx), "rresp");
    check(s_axi_rdata, exp_resp(idx) == `RESP_OKAY ? mdl[idx] : 0, "rdata");
  endtask

  initial begin
    for (int i = 0; i < 7; i++) mdl[idxs[i]] = rsts[i];
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(8'h2c);
    wr(8'h2c, 8'h5a);
    wr(8'h00, 8'h01);
    rd(8'h01);
    for (int i = 0; i < 7; i++) rd(idxs[i]);
    s_axi_wstrb <= 4'h0;
    wr(8'h30, 8'h12);
    s_axi_wstrb <= 4'hf;
    rd(8'h30);
    for (int n = 0; n < 18; n++) begin
      rv = xs();
      wr(idxs[n%6+1], rv[7:0]);
      rd(idxs[n%6+1]);
    end
    // Data-rate clock and falling receive edge, so routing updates every bit
    wr(8'h2e, 8'h00);
    for (int m = 0; m < 4; m++) begin
      rv = xs();
      wr(8'h2c, {4'h6, m[1:0], 2'b00});
      wr(8'h36, rv[7:0]);
      repeat (4) @(posedge clk);
      check(port_mode_q, m, "mode");
      check(high_nibble_q, exp_hn(m, rv[7:0]), "nibble");
      check(clk_oe, 1, "clock oe");
    end
    for (int a = 0; a < 4; a++) begin
      rv = xs();
      upstream_line <= rv[3:0];
      wr(8'h2c, {6'h19, a[1:0]});
      repeat (16) @(posedge clk);
      check(in0_q, a[0] ? rv[2] : rv[0], "in0");
      check(in1_q, a[1] ? rv[3] : rv[1], "in1");
    end
    wr(8'h30, 8'h0f);
    for (int c = 0; c < 3; c++) begin
      wr(8'h2e, {4'h6, c[0], c[1], 2'b00});
      wr(8'h2c, {2'b11, c[1:0], 4'h0});
      repeat (48) @(posedge clk);
      check(clk_oe, 0, "clock oe");
      ntx = 0;
      nrx = 0;
      repeat (960) begin
        @(posedge clk);
        ntx += tx_strobe_q;
        nrx += rx_strobe_q;
      end
      ex = (c == 0) ? 60 : (c == 1) ? 80 : 120;
      check(ntx > ex - 3 && ntx < ex + 3, 1, "send rate");
      check(nrx > ex - 3 && nrx < ex + 3, 1, "receive rate");
    end
    // One slot of offset keeps every position inside a 16-bit frame
    wr(8'h32, 8'h03);
    for (int k = 0; k < 8; k++) begin
      wr(8'h34, {1'b0, k[2:0], 4'(k + 5)});
      repeat (4) @(posedge clk);
      check((us_position_q + 1024 - ds_position_q) % 16, (adj(k) - adj(k + 5) + 16) % 16, "shift");
      check(us_position_q < 16, 1, "frame length");
    end
    nfr = 0;
    repeat (1280) begin
      @(posedge clk);
      nfr += frame_start_q;
    end
    check(nfr >= 9 && nfr <= 11, 1, "frames");
    test_done;
  end
endmodule // port_timing_setup_test
